// *** hw/rx_clock_and_freq_estimator.sv ***
// receive clocks, bit synchronizer, frequency error estimator and port
//
// Contract
// - filter clock: crystal over 6-bit divisor, then over 4 into phases, or over 2 when doubled
// - cut-off is crystal over 80 times divisor, or 40 when doubled
// - filter clock is twenty times cut-off, set by the divisor and the doubling bit
// - estimator takes up pulse per received one, down per zero
// - mode bits: off, count up, count down, up minus down
// - span bits choose 8, 16, 32 or 64 symbols per measurement
// - each finished measurement lands in the readable result register
// - result is 8-bit two's complement; down pulses make it negative, as does an up total past 127
// - synchronizer runs only in receive with synchronous mode enabled
// - data clock output runs at the bit rate
// - received bit changes on the rising edge of the data clock
// - sync clock is crystal over divisor times two to seven minus setting
// - separate 6-bit divisors for the filter clock and the sync clock
// - bit alignment reached within 22 symbols from packet start
// - synchronous mode off: data passes straight, no data clock
`timescale 1ns/1ps

// ========================================
// bit fifo between synchronizer and data pin
module bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wr;
      logic [AW:0]                 rd;
   } fifo_s;

   fifo_s s;
   fifo_s next_s;
   logic  full;
   logic  empty;

   assign full      = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);
   assign empty     = s.wr == s.rd;
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = s.mem[s.rd[AW-1:0]];

   always_comb begin
      next_s = s;
      if (in_valid && !full) begin
         next_s.mem[s.wr[AW-1:0]] = in_data;
         next_s.wr = s.wr + 1'b1;
      end
      if (out_ready && !empty) begin
         next_s.rd = s.rd + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ========================================
// top of the receive support logic
module rx_clock_and_freq_estimator (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // serial programming port
   input  wire logic prog_clk,
   input  wire logic prog_enable,
   input  wire logic prog_data_in,
   output logic      prog_data_out,
   output logic      prog_data_oe,
   // operating mode
   input  wire logic receive_mode,
   input  wire logic sync_enable,
   // demodulator
   input  wire logic demod_data,
   input  wire logic demod_up,
   input  wire logic demod_dn,
   // filter clock phases
   output logic      filter_phase1,
   output logic      filter_phase2,
   // data interface
   output logic      data_bit_clock,
   output logic      data_line_out,
   output logic      data_line_oe,
   // analogue controls
   output logic      signal_level_enable
);
   typedef struct packed {
      rx_pkg::regs_s      regs;
      rx_pkg::ser_state_e ser_st;
      logic               sclk_prev;
      logic [3:0]         bit_cnt;
      logic [7:0]         shift;
      logic [6:0]         addr;
      logic               rd_req;
      logic [7:0]         rd_shadow;
      logic               prog_data_out;
      logic               prog_data_oe;
      logic [5:0]         filt_cnt;
      logic [1:0]         filt_step;
      logic               filter_phase1;
      logic               filter_phase2;
      logic [5:0]         ref_cnt;
      logic [6:0]         pow_cnt;
      logic [3:0]         sync_phase;
      logic               data_prev;
      logic               data_bit_clock;
      logic               data_line_out;
      logic               data_line_oe;
      logic [6:0]         sym_cnt;
      logic [7:0]         fe_count;
   } top_s;

   top_s s;
   top_s next_s;

   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_data;
   logic fifo_push;
   logic fifo_pop;
   logic sample_tick;

   // ========================================
   // register read decode
   function automatic logic [7:0] read_reg(rx_pkg::regs_s r, logic [6:0] a);
      unique case (a)
         rx_pkg::ADDR_RX_CONFIG:    read_reg = r.rx_config_word;
         rx_pkg::ADDR_CLOCK_SEL_LO: read_reg = r.clock_select_low;
         rx_pkg::ADDR_CLOCK_SEL_HI: read_reg = r.clock_select_high;
         rx_pkg::ADDR_FILTER_DIV:   read_reg = r.filter_clock_divider;
         rx_pkg::ADDR_FE_CONTROL:   read_reg = r.freq_error_control;
         rx_pkg::ADDR_FE_RESULT:    read_reg = r.freq_error_result;
         default:                   read_reg = 8'h00;
      endcase
   endfunction

   bit_fifo #(
      .WIDTH (rx_pkg::FIFO_WIDTH),
      .DEPTH (rx_pkg::FIFO_DEPTH)
   ) u_bit_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (demod_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   always_comb begin
      logic       sclk_rise;
      logic       sclk_fall;
      logic [7:0] wdata;
      logic       filt_tick;
      logic       ref_tick;
      logic       sync_tick;
      logic       sync_run;
      logic [6:0] mask;
      logic [3:0] phase;
      logic [1:0] mode;
      logic [7:0] delta;
      logic [6:0] span;
      logic       fe_active;
      sclk_rise   = 1'b0;
      sclk_fall   = 1'b0;
      wdata       = 8'h00;
      filt_tick   = 1'b0;
      ref_tick    = 1'b0;
      sync_tick   = 1'b0;
      sync_run    = 1'b0;
      mask        = 7'h00;
      phase       = 4'h0;
      mode        = 2'b00;
      delta       = 8'h00;
      span        = 7'h00;
      fe_active   = 1'b0;
      sample_tick = 1'b0;
      fifo_push   = 1'b0;
      fifo_pop    = 1'b0;
      next_s      = s;

      // ========================================
      // serial programming port: 7 address bits, read flag, 8 data bits
      sclk_rise = prog_clk && !s.sclk_prev;
      sclk_fall = !prog_clk && s.sclk_prev;
      next_s.sclk_prev = prog_clk;
      if (!prog_enable) begin
         next_s.ser_st       = rx_pkg::SER_IDLE;
         next_s.bit_cnt      = 4'h0;
         next_s.prog_data_oe = 1'b0;
      end else if (sclk_rise) begin
         next_s.shift   = {s.shift[6:0], prog_data_in};
         next_s.bit_cnt = s.bit_cnt + 4'h1;
         unique case (s.ser_st)
            rx_pkg::SER_IDLE, rx_pkg::SER_ADDR: begin
               next_s.ser_st = rx_pkg::SER_ADDR;
               if (s.bit_cnt == rx_pkg::SER_LAST_BIT) begin
                  next_s.addr      = s.shift[6:0];
                  next_s.rd_req    = prog_data_in;
                  next_s.rd_shadow = read_reg(s.regs, s.shift[6:0]);
                  next_s.bit_cnt   = 4'h0;
                  next_s.ser_st    = rx_pkg::SER_DATA;
               end
            end
            rx_pkg::SER_DATA: begin
               if (s.bit_cnt == rx_pkg::SER_LAST_BIT) begin
                  next_s.bit_cnt = 4'h0;
                  next_s.ser_st  = rx_pkg::SER_ADDR;
                  wdata = {s.shift[6:0], prog_data_in};
                  if (!s.rd_req) begin
                     unique case (s.addr)
                        rx_pkg::ADDR_RX_CONFIG:
                           next_s.regs.rx_config_word = wdata;
                        rx_pkg::ADDR_CLOCK_SEL_LO:
                           next_s.regs.clock_select_low = wdata;
                        rx_pkg::ADDR_CLOCK_SEL_HI:
                           next_s.regs.clock_select_high = wdata;
                        rx_pkg::ADDR_FILTER_DIV:
                           next_s.regs.filter_clock_divider = wdata;
                        rx_pkg::ADDR_FE_CONTROL:
                           next_s.regs.freq_error_control =
                              wdata & rx_pkg::FE_CONTROL_MASK;
                        // result is read only; other writes are dropped
                        default: begin
                        end
                     endcase
                  end
               end
            end
         endcase
      end else if (sclk_fall && s.ser_st == rx_pkg::SER_DATA && s.rd_req) begin
         // read data leaves on falling edges, taken on the next rise
         next_s.prog_data_out = s.rd_shadow[7];
         next_s.rd_shadow     = {s.rd_shadow[6:0], 1'b0};
         next_s.prog_data_oe  = 1'b1;
      end

      // ========================================
      // filter divisor then four-phase step
      filt_tick = rx_pkg::div_tick(s.filt_cnt,
         s.regs.filter_clock_divider[rx_pkg::DIVISOR_MSB:0]);
      next_s.filt_cnt = filt_tick ? 6'h00 : s.filt_cnt + 6'h01;
      if (filt_tick) begin
         // doubling: two steps instead of four
         if (s.regs.filter_clock_divider[rx_pkg::CUTOFF_DOUBLE_BIT]) begin
            next_s.filt_step = {1'b0, !s.filt_step[0]};
         end else begin
            next_s.filt_step = s.filt_step + 2'h1;
         end
      end
      // phases never overlap: one step each
      next_s.filter_phase1 = next_s.filt_step == 2'h0;
      if (s.regs.filter_clock_divider[rx_pkg::CUTOFF_DOUBLE_BIT]) begin
         next_s.filter_phase2 = next_s.filt_step == 2'h1;
      end else begin
         next_s.filter_phase2 = next_s.filt_step == rx_pkg::FILT_PHASE_TWO;
      end

      // ========================================
      // synchronizer clock only in receive with sync enabled
      sync_run = receive_mode && sync_enable;
      ref_tick = sync_run && rx_pkg::div_tick(s.ref_cnt,
         s.regs.clock_select_high[rx_pkg::DIVISOR_MSB:0]);
      // power-of-two prescale by seven minus setting
      mask = rx_pkg::PRESCALE_FULL >>
         s.regs.clock_select_low[rx_pkg::PRESCALE_MSB:rx_pkg::PRESCALE_LSB];
      sync_tick = ref_tick && ((s.pow_cnt & mask) == mask);
      if (!sync_run) begin
         next_s.ref_cnt    = 6'h00;
         next_s.pow_cnt    = 7'h00;
         next_s.sync_phase = 4'h0;
      end else if (ref_tick) begin
         next_s.ref_cnt = 6'h00;
         next_s.pow_cnt = s.pow_cnt + 7'h01;
      end else begin
         next_s.ref_cnt = s.ref_cnt + 6'h01;
      end

      // one phase step per data edge, at most eight needed
      phase = s.sync_phase;
      if (sync_tick) begin
         next_s.data_prev = demod_data;
         if (demod_data != s.data_prev && s.sync_phase != 4'h0) begin
            if (s.sync_phase < rx_pkg::SYNC_SAMPLE_PHASE) begin
               phase = s.sync_phase;
            end else begin
               phase = s.sync_phase + 4'h2;
            end
         end else begin
            phase = s.sync_phase + 4'h1;
         end
         next_s.sync_phase = phase;
         sample_tick = phase == rx_pkg::SYNC_SAMPLE_PHASE;
      end

      // ========================================
      // data pin: buffered bits in sync mode, straight through otherwise
      next_s.data_line_oe = receive_mode;
      if (sync_run) begin
         // bit is lost only if the buffer is full
         fifo_push = sample_tick && fifo_in_ready;
         // new bit leaves with the rising data clock
         fifo_pop  = sample_tick && fifo_out_valid;
         if (fifo_pop) begin
            next_s.data_line_out = fifo_out_data;
         end
         // one data clock period per bit
         next_s.data_bit_clock = next_s.sync_phase[3];
      end else begin
         // transparent data, clock held low, buffer drained
         fifo_pop              = fifo_out_valid;
         next_s.data_line_out  = demod_data;
         next_s.data_bit_clock = 1'b0;
      end

      // ========================================
      // frequency error estimator
      mode = s.regs.freq_error_control[rx_pkg::FE_MODE_MSB:0];
      fe_active = receive_mode && mode != 2'b00;
      // up per received one, down per received zero
      // up adds, down subtracts, per selected mode
      if (demod_up && mode[0]) begin
         delta = delta + 8'h01;
      end
      // down counts make the value negative
      if (demod_dn && mode[1]) begin
         delta = delta - 8'h01;
      end
      // span of 8 to 64 symbols
      span = rx_pkg::FE_BASE_SYMBOLS <<
         s.regs.freq_error_control[rx_pkg::FE_SPAN_MSB:rx_pkg::FE_SPAN_LSB];
      if (!fe_active) begin
         next_s.fe_count = 8'h00;
         next_s.sym_cnt  = 7'h00;
      end else begin
         next_s.fe_count = s.fe_count + delta;
         if (sample_tick) begin
            next_s.sym_cnt = s.sym_cnt + 7'h01;
            // span may shrink mid-count: close at once, never wrap
            if (s.sym_cnt + 7'h01 >= span) begin
               // finished measurement to the result register
               next_s.regs.freq_error_result = s.fe_count + delta;
               next_s.fe_count = 8'h00;
               next_s.sym_cnt  = 7'h00;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.regs.rx_config_word       <= rx_pkg::RST_RX_CONFIG;
         s.regs.clock_select_low     <= rx_pkg::RST_CLOCK_SEL_LO;
         s.regs.clock_select_high    <= rx_pkg::RST_CLOCK_SEL_HI;
         s.regs.filter_clock_divider <= rx_pkg::RST_FILTER_DIV;
         s.regs.freq_error_control   <= rx_pkg::RST_FE_CONTROL;
         s.regs.freq_error_result    <= rx_pkg::RST_FE_RESULT;
         s.ser_st                    <= rx_pkg::SER_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // ========================================
   // outputs straight from state
   assign prog_data_out       = s.prog_data_out;
   assign prog_data_oe        = s.prog_data_oe;
   assign filter_phase1       = s.filter_phase1;
   assign filter_phase2       = s.filter_phase2;
   assign data_bit_clock      = s.data_bit_clock;
   assign data_line_out       = s.data_line_out;
   assign data_line_oe        = s.data_line_oe;
   assign signal_level_enable =
      s.regs.rx_config_word[rx_pkg::SIG_LEVEL_EN_BIT];
endmodule

// *** common/rx_pkg.sv ***
// shared constants and types of the receive clock and error estimator
package rx_pkg;
   // ========================================
   // register addresses on the serial port
   localparam logic [6:0] ADDR_RX_CONFIG     = 7'h01;
   localparam logic [6:0] ADDR_CLOCK_SEL_LO  = 7'h06;
   localparam logic [6:0] ADDR_CLOCK_SEL_HI  = 7'h07;
   localparam logic [6:0] ADDR_FILTER_DIV    = 7'h08;
   localparam logic [6:0] ADDR_FE_CONTROL    = 7'h15;
   localparam logic [6:0] ADDR_FE_RESULT     = 7'h16;

   // ========================================
   // values after reset
   localparam logic [7:0] RST_RX_CONFIG      = 8'h00;
   localparam logic [7:0] RST_CLOCK_SEL_LO   = 8'h00;
   localparam logic [7:0] RST_CLOCK_SEL_HI   = 8'h01;
   localparam logic [7:0] RST_FILTER_DIV     = 8'h81;
   localparam logic [7:0] RST_FE_CONTROL     = 8'h00;
   localparam logic [7:0] RST_FE_RESULT      = 8'h00;

   // ========================================
   // field positions
   localparam int SIG_LEVEL_EN_BIT  = 3;
   localparam int CUTOFF_DOUBLE_BIT = 6;
   localparam int DIVISOR_MSB       = 5;
   localparam int PRESCALE_LSB      = 1;
   localparam int PRESCALE_MSB      = 3;
   localparam int FE_MODE_MSB       = 1;
   localparam int FE_SPAN_LSB       = 2;
   localparam int FE_SPAN_MSB       = 3;
   localparam logic [7:0] FE_CONTROL_MASK = 8'h0f;

   // ========================================
   // counts of cycles and phases
   localparam logic [1:0] FILT_LAST_PHASE   = 2'h3;
   localparam logic [1:0] FILT_PHASE_TWO    = 2'h2;
   localparam logic [6:0] PRESCALE_FULL     = 7'h7f;
   localparam logic [3:0] SYNC_SAMPLE_PHASE = 4'h8;
   localparam logic [6:0] FE_BASE_SYMBOLS   = 7'h08;
   localparam logic [3:0] SER_LAST_BIT      = 4'h7;
   localparam int FIFO_WIDTH = 1;
   localparam int FIFO_DEPTH = 8;

   // ========================================
   // types
   typedef enum logic [1:0] {
      SER_IDLE = 2'b00,
      SER_ADDR = 2'b01,
      SER_DATA = 2'b11
   } ser_state_e;

   typedef struct packed {
      logic [7:0] rx_config_word;
      logic [7:0] clock_select_low;
      logic [7:0] clock_select_high;
      logic [7:0] filter_clock_divider;
      logic [7:0] freq_error_control;
      logic [7:0] freq_error_result;
   } regs_s;

   // divider tick: counter reached divisor minus one (0 and 1 tick always)
   function automatic logic div_tick(logic [5:0] cnt, logic [5:0] div);
      div_tick = ({1'b0, cnt} + 7'h01) >= {1'b0, div};
   endfunction
endpackage

// *** bench/rx_clock_and_freq_estimator_sva.sv ***
// port assertions of the receive clock and error estimator
`timescale 1ns/1ps
module rx_clock_and_freq_estimator_sva (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // serial programming port
   input wire logic prog_clk,
   input wire logic prog_enable,
   input wire logic prog_data_in,
   input wire logic prog_data_out,
   input wire logic prog_data_oe,
   // operating mode
   input wire logic receive_mode,
   input wire logic sync_enable,
   // demodulator
   input wire logic demod_data,
   input wire logic demod_up,
   input wire logic demod_dn,
   // filter clock phases
   input wire logic filter_phase1,
   input wire logic filter_phase2,
   // data interface
   input wire logic data_bit_clock,
   input wire logic data_line_out,
   input wire logic data_line_oe,
   // analogue controls
   input wire logic signal_level_enable
);
   logic sync_on;

   assign sync_on = receive_mode && sync_enable;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // ========================================
   // filter clock
   AST_PHASE_EXCL:
      assert property (!(filter_phase1 && filter_phase2))
      else $error("filter phases overlap");
   // slowest divisor gives 252 cycles, margin for reprogramming
   AST_PHASE_RUNS:
      assert property ($rose(filter_phase1) |-> ##[2:1000] $rose(filter_phase1))
      else $error("filter phase one stopped");

   // ========================================
   // data interface
   AST_CLK_OFF:
      assert property (!sync_on && $past(!sync_on) |-> !data_bit_clock)
      else $error("data clock runs outside synchronous receive");
   AST_CLK_CAUSE:
      assert property ($rose(data_bit_clock) |-> $past(sync_on))
      else $error("data clock rose without synchronous receive");
   AST_PASS_THRU:
      assert property (receive_mode && !sync_enable
         && $past(receive_mode && !sync_enable)
         |-> data_line_out == $past(demod_data))
      else $error("received data not passed straight through");
   AST_DATA_ON_RISE:
      assert property (sync_on && $past(sync_on) && $past(sync_on, 2)
         && $changed(data_line_out) |-> $rose(data_bit_clock))
      else $error("data changed away from a data clock rise");
   AST_OE_RX:
      assert property (data_line_oe == $past(receive_mode))
      else $error("data line enable does not follow receive");
   AST_PROG_OE_IDLE:
      assert property (!prog_enable && $past(!prog_enable) |-> !prog_data_oe)
      else $error("serial data driven outside a frame");
endmodule

// *** bench/mcu_model.sv ***
// controller side: collects received bits from the data interface
`timescale 1ns/1ps
module mcu_model (
   // data interface from the device
   input wire logic data_bit_clock,
   input wire logic data_line_out,
   input wire logic data_line_oe
);
   logic got [$];

   // sample on falling edge
   // a released line reads as the inverse, never a stale copy
   always @(negedge data_bit_clock) begin
      got.push_back(data_line_oe ? data_line_out : ~data_line_out);
   end
endmodule

// *** bench/test_rx_clock_and_freq_estimator.sv ***
// self-checking bench of the receive clock and error estimator
`timescale 1ns/1ps
module test_rx_clock_and_freq_estimator;
   logic       clk_sys, rst, prog_clk, prog_enable, prog_data_in;
   logic       receive_mode, sync_enable, demod_data, demod_up, demod_dn;
   logic       prog_data_out, prog_data_oe, filter_phase1, filter_phase2;
   logic       data_bit_clock, data_line_out, data_line_oe;
   logic       signal_level_enable, pulse_en, dat_en, ok, m_ok;
   logic [1:0] m;
   logic [7:0] rd;
   logic [7:0] lfsr = 8'h26;
   logic [6:0] adr [7];
   logic [7:0] rsv [7];
   logic [5:0] kv [3] = '{6'h01, 6'h05, 6'h3f};
   logic       sent [$];
   int         num_errors = 0, checked = 0, cyc = 0, n, e;

   rx_clock_and_freq_estimator u_rx_clock_and_freq_estimator (
      .clk_sys(clk_sys), .rst(rst), .prog_clk(prog_clk),
      .prog_enable(prog_enable), .prog_data_in(prog_data_in),
      .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
      .receive_mode(receive_mode), .sync_enable(sync_enable),
      .demod_data(demod_data), .demod_up(demod_up), .demod_dn(demod_dn),
      .filter_phase1(filter_phase1), .filter_phase2(filter_phase2),
      .data_bit_clock(data_bit_clock), .data_line_out(data_line_out),
      .data_line_oe(data_line_oe),
      .signal_level_enable(signal_level_enable));

   mcu_model u_mcu_model (
      .data_bit_clock(data_bit_clock), .data_line_out(data_line_out),
      .data_line_oe(data_line_oe));

   // ========================================
   // helpers
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one serial frame, msb first; w high writes, low reads into rd
   task automatic frame(input logic [6:0] a, input logic w,
                        input logic [7:0] d);
      logic [15:0] bits;
      bits = {a, ~w, d};
      rd = 8'h00;
      prog_enable <= 1'b1;
      for (int i = 15; i >= 0; i--) begin
         prog_clk <= 1'b0;
         prog_data_in <= bits[i];
         repeat (3) @(posedge clk_sys);
         if (i < 8) rd[i] = prog_data_oe ? prog_data_out : ~prog_data_out;
         prog_clk <= 1'b1;
         repeat (2) @(posedge clk_sys);
      end
      prog_clk <= 1'b0;
      repeat (3) @(posedge clk_sys);
      prog_enable <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   // cycles between second and third rise; first may be cut short
   task automatic period(input logic [1:0] sel, output int n);
      int   k;
      logic p, c;
      n = 0;
      k = 0;
      p = 1'b1;
      repeat (2000) begin
         @(posedge clk_sys);
         c = sel[1] ? filter_phase2
             : (sel[0] ? data_bit_clock : filter_phase1);
         if (c && !p) k++;
         if (k == 3) break;
         if (k == 2) n++;
         p = c;
      end
   endtask

   task automatic end_of_test;
      $display("errors %0d, checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ========================================
   // clock, demodulator stimulus, time limit
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // pulses: three up, one down per symbol
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      demod_up <= pulse_en && (cyc % 16 inside {0, 4, 8});
      demod_dn <= pulse_en && (cyc % 16 == 2);
      if (dat_en && cyc % 16 == 0) begin
         demod_data <= lfsr[0];
         sent.push_back(lfsr[0]);
         lfsr <= lfsr_next(lfsr);
      end
   end

   always @(posedge clk_sys) begin
      if (cyc == 20000) begin
         num_errors++;
         end_of_test();
      end
   end

   // ========================================
   // main sequence
   initial begin
      rst = 1'b1;
      {prog_clk, prog_enable, prog_data_in, receive_mode} = 4'h0;
      {sync_enable, demod_data, demod_up, demod_dn} = 4'h0;
      {pulse_en, dat_en} = 2'b00;
      adr = '{rx_pkg::ADDR_RX_CONFIG, rx_pkg::ADDR_CLOCK_SEL_LO,
              rx_pkg::ADDR_CLOCK_SEL_HI, rx_pkg::ADDR_FILTER_DIV,
              rx_pkg::ADDR_FE_CONTROL, rx_pkg::ADDR_FE_RESULT, 7'h20};
      rsv = '{rx_pkg::RST_RX_CONFIG, rx_pkg::RST_CLOCK_SEL_LO,
              rx_pkg::RST_CLOCK_SEL_HI, rx_pkg::RST_FILTER_DIV,
              rx_pkg::RST_FE_CONTROL, rx_pkg::RST_FE_RESULT, 8'h00};
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 7; i++) begin
         frame(adr[i], 1'b0, 8'h00);
         chk(rd, rsv[i]);
      end
      // read-only result, masked control, unmapped place
      frame(rx_pkg::ADDR_FE_CONTROL, 1'b1, 8'hff);
      frame(rx_pkg::ADDR_FE_RESULT, 1'b1, 8'h5a);
      frame(7'h20, 1'b1, 8'h77);
      frame(rx_pkg::ADDR_RX_CONFIG, 1'b1, 8'h08);
      chk({7'h00, signal_level_enable}, 8'h01);
      frame(rx_pkg::ADDR_FE_CONTROL, 1'b0, 8'h00);
      chk(rd, 8'h0f);
      frame(rx_pkg::ADDR_FE_RESULT, 1'b0, 8'h00);
      chk(rd, 8'h00);
      frame(7'h20, 1'b0, 8'h00);
      chk(rd, 8'h00);
      foreach (kv[i]) begin
         for (int x = 0; x < 2; x++) begin
            frame(rx_pkg::ADDR_FILTER_DIV, 1'b1, {1'b1, x[0], kv[i]});
            period(2'h0, n);
            e = (x ? 2 : 4) * kv[i];
            chk(n[7:0], e[7:0]);
            period(2'h2, n);
            chk(n[7:0], e[7:0]);
         end
      end
      // synchronizer at one tick a cycle, sixteen per bit
      frame(rx_pkg::ADDR_CLOCK_SEL_HI, 1'b1, 8'h01);
      frame(rx_pkg::ADDR_CLOCK_SEL_LO, 1'b1, 8'h0e);
      receive_mode <= 1'b1;
      sync_enable <= 1'b1;
      dat_en <= 1'b1;
      repeat (24 * 16) @(posedge clk_sys);
      #1;
      sent.delete();
      u_mcu_model.got.delete();
      repeat (32 * 16) @(posedge clk_sys);
      ok = 1'b0;
      for (int d = 0; d < 5; d++) begin
         m_ok = u_mcu_model.got.size() > 20;
         for (int i = d; i < u_mcu_model.got.size(); i++)
            if (u_mcu_model.got[i] !== sent[i - d]) m_ok = 1'b0;
         ok = ok | m_ok;
      end
      chk({7'h00, ok}, 8'h01);
      // quiet data, so no phase steps disturb the period
      dat_en <= 1'b0;
      period(2'h1, n);
      chk(n[7:0], 8'h10);
      frame(rx_pkg::ADDR_CLOCK_SEL_LO, 1'b1, 8'h0c);
      period(2'h1, n);
      chk(n[7:0], 8'h20);
      frame(rx_pkg::ADDR_CLOCK_SEL_LO, 1'b1, 8'h0e);
      pulse_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         m = (i < 3) ? 2'(i + 1) : 2'h3;
         frame(rx_pkg::ADDR_FE_CONTROL, 1'b1, {4'h0, i[1:0], m});
         repeat ((2 * (8 << i) + 2) * 16) @(posedge clk_sys);
         frame(rx_pkg::ADDR_FE_RESULT, 1'b0, 8'h00);
         e = (8 << i) * ((m[0] ? 3 : 0) - (m[1] ? 1 : 0));
         chk(rd, e[7:0]);
      end
      sync_enable <= 1'b0;
      dat_en <= 1'b1;
      repeat (20 * 16) @(posedge clk_sys);
      chk({7'h00, data_bit_clock}, 8'h00);
      receive_mode <= 1'b0;
      repeat (16) @(posedge clk_sys);
      end_of_test();
   end
endmodule

bind rx_clock_and_freq_estimator rx_clock_and_freq_estimator_sva
   u_rx_clock_and_freq_estimator_sva (
   .clk_sys(clk_sys), .rst(rst), .prog_clk(prog_clk),
   .prog_enable(prog_enable), .prog_data_in(prog_data_in),
   .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
   .receive_mode(receive_mode), .sync_enable(sync_enable),
   .demod_data(demod_data), .demod_up(demod_up), .demod_dn(demod_dn),
   .filter_phase1(filter_phase1), .filter_phase2(filter_phase2),
   .data_bit_clock(data_bit_clock), .data_line_out(data_line_out),
   .data_line_oe(data_line_oe),
   .signal_level_enable(signal_level_enable));
